// file: src/rsc_defines.svh
// Strap loader constants: config indices, bit positions, codes and reset values
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
`define RSC_IDX_COMMAND 8'h04
`define RSC_IDX_PROG_IF 8'h09
`define RSC_IDX_SUBCLASS 8'h0a
`define RSC_IDX_SUBSYS_CTL 8'h4f
`define RSC_IDX_CHAN_CTL 8'h51
`define RSC_SUBCLASS_RAID 8'h04
`define RSC_SUBCLASS_IDE 8'h01
`define RSC_PROG_IF_RAID 8'h00
`define RSC_BIT_PRI_NATIVE 0
`define RSC_BIT_PRI_CAPABLE 1
`define RSC_BIT_SEC_NATIVE 2
`define RSC_BIT_SEC_CAPABLE 3
`define RSC_BIT_IO_ENABLE 0
`define RSC_BIT_ROM_ENABLE 1
`define RSC_BIT_SUBSYS_LOAD 1
`define RSC_BIT_PRI_STRAP 2
`define RSC_BIT_SEC_STRAP 3
`define RSC_IRQ_LEGACY_PRI 4'he
`define RSC_IRQ_LEGACY_SEC 4'hf
`define RSC_PORT_LEGACY_PRI 16'h01f0
`define RSC_PORT_LEGACY_SEC 16'h0170
`define RSC_SUBSYS_ID_DEFAULT 16'h5a5a
`define RSC_SUBSYS_VID_DEFAULT 16'ha5a5
`endif

// file: src/rsc_pkg.sv
// Types shared by the strap loader modules
package rsc_pkg;
  typedef enum logic [2:0] {
    RSC_ST_RESET = 3'h1,
    RSC_ST_CAPTURE = 3'h2,
    RSC_ST_RUN = 3'h4
  } rsc_state_t;
endpackage : rsc_pkg

// file: src/rsc_strap_latch.sv
// Strap latch: samples strap pins while reset is held, then freezes them
`timescale 1ns/10ps
module rsc_strap_latch
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Straps
  input wire logic [7:0] strap_pins,
  output logic [7:0] strap_q
);
  logic [7:0] strap_d;

  always_comb
  begin
    strap_d = strap_q;
    if (reset)
    begin
      strap_d = strap_pins;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    strap_q <= strap_d;
  end
endmodule : rsc_strap_latch

// file: src/rsc_prog_if.sv
// Programming interface byte: native/legacy mode bits per channel
`timescale 1ns/10ps
`include "rsc_defines.svh"
module rsc_prog_if
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  // Strap levels
  input wire logic class_ide,
  input wire logic native_capable,
  input wire logic powerup_native,
  // Software write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] prog_if
);
  logic pri_native_q;
  logic pri_native_d;
  logic sec_native_q;
  logic sec_native_d;

  always_comb
  begin
    pri_native_d = pri_native_q;
    sec_native_d = sec_native_q;
    if (reset || load)
    begin
      pri_native_d = native_capable & powerup_native;
      sec_native_d = native_capable & powerup_native;
    end
    else if (wr_en && class_ide && native_capable)
    begin
      pri_native_d = wr_data[`RSC_BIT_PRI_NATIVE];
      sec_native_d = wr_data[`RSC_BIT_SEC_NATIVE];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    pri_native_q <= pri_native_d;
    sec_native_q <= sec_native_d;
  end

  always_comb
  begin
    prog_if = 8'h00;
    prog_if[`RSC_BIT_PRI_CAPABLE] = native_capable;
    prog_if[`RSC_BIT_SEC_CAPABLE] = native_capable;
    prog_if[`RSC_BIT_PRI_NATIVE] = pri_native_q;
    prog_if[`RSC_BIT_SEC_NATIVE] = sec_native_q;
    if (!class_ide)
    begin
      prog_if = `RSC_PROG_IF_RAID;
    end
  end
endmodule : rsc_prog_if

// file: src/rsc_strap_config.sv
// Reset strap configuration loader for the IDE/ATA host controller
// Summary of operation
// - Class strap low gives RAID sub-class 04, high gives IDE 01.
// - Native-capability strap low makes base address registers read zero.
// - Capability strap low routes channel interrupts to IRQ14 and IRQ15.
// - Capability strap low fixes legacy ports and ignores native selection.
// - Capability strap high reports native capability in bits 1 and 3 in IDE class.
// - Mode strap low starts native, high legacy; only if capable and in IDE class (RAID decodes legacy).
// - Software switches channel modes through programming interface bits 0 and 2.
// - Mode bits writable only in IDE class; RAID reads zero.
// - Primary strap low blocks primary access and interrupt; shows bit 2.
// - Primary enabled only with strap high and I/O space enable set.
// - Secondary strap low enables, high disables; shows in bit 3.
// - Default-operation strap low leaves disk cycles off until software enables.
// - Default-operation strap high forces disk cycles on permanently.
// - Subsystem-load strap high loads default identifiers; reflected in bit 1.
// - ROM strap enables or disables expansion ROM; reflected in command bit 1.
// - Bus reset returns internal registers to initial values, except the subsystem identifiers.
`timescale 1ns/10ps
`include "rsc_defines.svh"
module rsc_strap_config
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Strap pins, low means a pull-down is fitted
  input wire logic class_select_strap,
  input wire logic native_capable_strap,
  input wire logic powerup_mode_strap,
  input wire logic primary_channel_strap,
  input wire logic secondary_channel_strap,
  input wire logic default_operation_strap,
  input wire logic subsystem_load_strap,
  input wire logic rom_support_strap,
  // Software writes to the command register bit 0
  input wire logic command_wr,
  input wire logic io_enable_wr_data,
  // Software writes to the programming interface byte
  input wire logic prog_if_wr,
  input wire logic [7:0] prog_if_wr_data,
  // Configuration results
  output logic [7:0] subclass_code,
  output logic [7:0] programming_interface_byte,
  output logic [7:0] chan_ctl_byte,
  output logic [7:0] subsys_ctl_byte,
  output logic io_space_enable,
  output logic rom_enable,
  output logic bar_read_zero,
  output logic legacy_decode_pri,
  output logic legacy_decode_sec,
  output logic [15:0] pri_port_base,
  output logic [15:0] sec_port_base,
  output logic [3:0] pri_irq_line,
  output logic [3:0] sec_irq_line,
  output logic primary_enable,
  output logic primary_irq_enable,
  output logic secondary_enable,
  output logic subsys_load,
  output logic [15:0] subsys_id,
  output logic [15:0] subsys_vendor_id
);
  logic [7:0] strap_q;
  logic [7:0] pins;
  rsc_state_t state_q;
  rsc_state_t state_d;
  logic io_en_q;
  logic io_en_d;
  logic [15:0] ssid_q;
  logic [15:0] ssid_d;
  logic [15:0] ssvid_q;
  logic [15:0] ssvid_d;
  logic load;
  logic cls_ide;
  logic capable;

  assign pins = {rom_support_strap, subsystem_load_strap, default_operation_strap,
                 secondary_channel_strap, primary_channel_strap, powerup_mode_strap,
                 native_capable_strap, class_select_strap};

  rsc_strap_latch u_latch (
    .ref_clk(ref_clk),
    .reset(reset),
    .strap_pins(pins),
    .strap_q(strap_q)
  );

  assign cls_ide = strap_q[0];
  assign capable = strap_q[1];
  // One-cycle load pulse after reset release so latched straps seed registers
  assign load = (state_q == RSC_ST_CAPTURE);

  always_comb
  begin
    case (state_q)
      RSC_ST_RESET: state_d = RSC_ST_CAPTURE;
      RSC_ST_CAPTURE: state_d = RSC_ST_RUN;
      RSC_ST_RUN: state_d = RSC_ST_RUN;
      default: state_d = RSC_ST_RESET;
    endcase
    if (reset)
    begin
      state_d = RSC_ST_RESET;
    end
  end

  always_comb
  begin
    io_en_d = io_en_q;
    ssid_d = ssid_q;
    ssvid_d = ssvid_q;
    if (reset)
    begin
      io_en_d = 1'b0;
    end
    else if (load)
    begin
      io_en_d = strap_q[5];
      if (strap_q[6])
      begin
        ssid_d = `RSC_SUBSYS_ID_DEFAULT;
        ssvid_d = `RSC_SUBSYS_VID_DEFAULT;
      end
    end
    else if (command_wr && !strap_q[5])
    begin
      io_en_d = io_enable_wr_data;
    end
  end

  // Ids are not cleared by reset: a low load strap must keep prior values
  always_ff @(posedge ref_clk)
  begin
    state_q <= state_d;
    io_en_q <= io_en_d;
    ssid_q <= ssid_d;
    ssvid_q <= ssvid_d;
  end

  rsc_prog_if u_prog_if (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(load),
    .class_ide(cls_ide),
    .native_capable(capable),
    .powerup_native(~strap_q[2]),
    .wr_en(prog_if_wr),
    .wr_data(prog_if_wr_data),
    .prog_if(programming_interface_byte)
  );

  always_comb
  begin
    subclass_code = cls_ide ? `RSC_SUBCLASS_IDE : `RSC_SUBCLASS_RAID;
    bar_read_zero = ~capable;
    legacy_decode_pri = ~capable | ~programming_interface_byte[`RSC_BIT_PRI_NATIVE];
    legacy_decode_sec = ~capable | ~programming_interface_byte[`RSC_BIT_SEC_NATIVE];
    pri_port_base = `RSC_PORT_LEGACY_PRI;
    sec_port_base = `RSC_PORT_LEGACY_SEC;
    pri_irq_line = `RSC_IRQ_LEGACY_PRI;
    sec_irq_line = `RSC_IRQ_LEGACY_SEC;
    io_space_enable = io_en_q;
    primary_enable = strap_q[3] & io_en_q;
    primary_irq_enable = strap_q[3] & io_en_q;
    secondary_enable = ~strap_q[4];
    chan_ctl_byte = 8'h00;
    chan_ctl_byte[`RSC_BIT_PRI_STRAP] = strap_q[3];
    chan_ctl_byte[`RSC_BIT_SEC_STRAP] = strap_q[4];
    subsys_load = strap_q[6];
    subsys_ctl_byte = 8'h00;
    subsys_ctl_byte[`RSC_BIT_SUBSYS_LOAD] = strap_q[6];
    rom_enable = strap_q[7];
    subsys_id = ssid_q;
    subsys_vendor_id = ssvid_q;
  end
endmodule : rsc_strap_config

// file: tb/rsc_strap_board.sv
// Board model: one pull-down per strap, no pull-down reads high
`timescale 1ns/10ps
module rsc_strap_board
(
  // Fitted pull-downs, one bit per strap
  input wire logic [7:0] pulldown_fit,
  // Strap levels seen by the device
  output logic [7:0] strap_pins
);
  assign strap_pins = ~pulldown_fit;
endmodule : rsc_strap_board

// file: tb/rsc_strap_properties.sv
// Checker for the strap loader outputs
`timescale 1ns/10ps
module rsc_strap_properties
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Writes
  input wire logic command_wr,
  input wire logic prog_if_wr,
  input wire logic [7:0] prog_if_wr_data,
  // Results
  input wire logic [7:0] subclass_code,
  input wire logic [7:0] programming_interface_byte,
  input wire logic [7:0] chan_ctl_byte,
  input wire logic io_space_enable,
  input wire logic rom_enable,
  input wire logic bar_read_zero,
  input wire logic legacy_decode_pri,
  input wire logic [3:0] pri_irq_line,
  input wire logic primary_enable,
  input wire logic secondary_enable
);
  logic [1:0] age_q;
  logic [1:0] age_d;
  logic ready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Outputs only settle two edges after release
  always_comb
  begin
    age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
  end
  always_ff @(posedge ref_clk)
  begin
    age_q <= reset ? 2'h0 : age_d;
  end
  assign ready = (age_q == 2'h3);
  a_class_code: assert property (ready |-> subclass_code inside {8'h04, 8'h01})
    else $error("subclass code illegal");
  a_raid_zero: assert property (ready && subclass_code == 8'h04 |-> programming_interface_byte == 8'h00)
    else $error("mode byte not zero in raid class");
  a_bar_legacy: assert property (ready && bar_read_zero |-> legacy_decode_pri && programming_interface_byte[3:0] == 4'h0)
    else $error("not capable but native shown");
  a_legacy_irq: assert property (ready && bar_read_zero |-> pri_irq_line == 4'he)
    else $error("legacy primary irq wrong");
  a_pri_gate: assert property (ready |-> primary_enable == (chan_ctl_byte[2] && io_space_enable))
    else $error("primary enable gating wrong");
  a_sec_gate: assert property (ready |-> secondary_enable == !chan_ctl_byte[3])
    else $error("secondary enable polarity wrong");
  a_io_hold: assert property (ready && !command_wr |=> $stable(io_space_enable))
    else $error("io enable moved without write");
  a_straps_frozen: assert property (ready |=> $stable(rom_enable) && $stable(chan_ctl_byte))
    else $error("latched strap changed");
  a_mode_write: assert property (ready && prog_if_wr && subclass_code == 8'h01 && !bar_read_zero
    |=> programming_interface_byte[2] == $past(prog_if_wr_data[2]))
    else $error("mode bit write lost");
  c_mode_write: cover property (ready && prog_if_wr);
  c_cmd_write: cover property (ready && command_wr);
  c_raid: cover property (ready && subclass_code == 8'h04);
endmodule : rsc_strap_properties
bind rsc_strap_config rsc_strap_properties rsc_strap_properties_i (.*);

// file: tb/rsc_strap_config_bench.sv
// Self-checking bench for the strap loader
`timescale 1ns/10ps
module rsc_strap_config_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] fit = 8'h00;
  logic [7:0] pins;
  logic command_wr = 1'b0;
  logic io_enable_wr_data = 1'b0;
  logic prog_if_wr = 1'b0;
  logic [7:0] prog_if_wr_data = 8'h00;
  logic [7:0] subclass_code, programming_interface_byte, chan_ctl_byte, subsys_ctl_byte;
  logic io_space_enable, rom_enable, bar_read_zero, legacy_decode_pri, legacy_decode_sec;
  logic [15:0] pri_port_base, sec_port_base, subsys_id, subsys_vendor_id;
  logic [3:0] pri_irq_line, sec_irq_line;
  logic primary_enable, primary_irq_enable, secondary_enable, subsys_load;
  logic [7:0] cfgs [5] = '{8'h00, 8'hff, 8'h04, 8'h5a, 8'ha5};
  logic [7:0] s;
  logic n;
  int error_cnt = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  rsc_strap_board rsc_strap_board_i (.pulldown_fit(fit), .strap_pins(pins));
  rsc_strap_config rsc_strap_config_i (.class_select_strap(pins[0]),
    .native_capable_strap(pins[1]), .powerup_mode_strap(pins[2]),
    .primary_channel_strap(pins[3]), .secondary_channel_strap(pins[4]),
    .default_operation_strap(pins[5]), .subsystem_load_strap(pins[6]),
    .rom_support_strap(pins[7]), .*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // Pins flip after release so frozen latches can be seen
  task automatic power_up(input logic [7:0] f);
    @(negedge ref_clk);
    fit = f;
    reset = 1'b1;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    fit = ~f;
  endtask : power_up
  task automatic sw_write(input logic sel, input logic [7:0] d);
    @(negedge ref_clk);
    command_wr = !sel;
    prog_if_wr = sel;
    io_enable_wr_data = d[0];
    prog_if_wr_data = d;
    @(negedge ref_clk);
    command_wr = 1'b0;
    prog_if_wr = 1'b0;
  endtask : sw_write
  initial
  begin
    foreach (cfgs[i])
    begin
      power_up(cfgs[i]);
      s = ~cfgs[i];
      n = s[1] && !s[2];
      check(subclass_code, s[0] ? 8'h01 : 8'h04);
      check(8'(bar_read_zero), 8'(!s[1]));
      check(programming_interface_byte, s[0] ? {4'h0, s[1], n, s[1], n} : 8'h00);
      check({6'h00, chan_ctl_byte[3:2]}, {6'h00, s[4], s[3]});
      check(8'(secondary_enable), 8'(!s[4]));
      check(8'(subsys_ctl_byte[1]), 8'(s[6]));
      check(8'(rom_enable), 8'(s[7]));
      check(8'(io_space_enable), 8'(s[5]));
      check({pri_irq_line, sec_irq_line}, 8'hef);
      check(8'(legacy_decode_pri | s[1]), 8'h01);
      check(8'(pri_port_base == 16'h01f0 && sec_port_base == 16'h0170), 8'h01);
      check(8'(legacy_decode_sec | s[1]), 8'h01);
      check(8'(subsys_load), 8'(s[6]));
      if (s[6]) check(subsys_id[7:0], 8'h5a);
      if (s[6]) check(subsys_vendor_id[15:8], 8'ha5);
      sw_write(1'b0, 8'h01);
      check(8'(primary_enable), 8'(s[3]));
      sw_write(1'b0, 8'h00);
      check(8'(io_space_enable), 8'(s[5]));
      check(8'(primary_irq_enable), 8'(s[3] && s[5]));
      sw_write(1'b1, 8'h05);
      check(programming_interface_byte & 8'h05, (s[0] && s[1]) ? 8'h05 : 8'h00);
      sw_write(1'b1, 8'h00);
      check(programming_interface_byte & 8'h05, 8'h00);
    end
    complete_run();
  end
  initial
  begin
    #5000;
    error_cnt++;
    complete_run();
  end
endmodule : rsc_strap_config_bench
